//--- logic/smc_supply_monitor.sv
// supply monitor control register, low supply flag and settling timer
`timescale 1ns/100ps
module smc_supply_monitor
	import smc_pkg::*;
#(
	parameter int SETTLE_CYCLES = SMC_SETTLE_CYCLES // 250 ms of clk_sys
)(
	input  wire logic          clk_sys,          // core clock, 20 MHz
	input  wire logic          rst_b,            // async reset, active low
	input  wire smc_sfr_req_t  sfrReq,           // register port request
	output logic [7:0]         sfrRdData,        // read data, next cycle
	input  wire logic          digitalRailCmp,   // digital comparator, async
	input  wire logic          analogRailCmp,    // analog comparator, async
	input  wire logic          monitorIrqEnable, // from irq enable register
	output logic               monitorEnable,    // switches the comparators
	output logic [1:0]         digitalTripSel,   // digital trip level code
	output logic [1:0]         analogTripSel,    // analog trip level code
	output logic               lowSupplyIrq      // interrupt request level
);

	// ****************************************************************
	// local constants
	// ****************************************************************
	// last count of the settling interval, cut to counter width
	localparam logic [SMC_SETTLE_W-1:0] SETTLE_LAST =
		SMC_SETTLE_W'(SETTLE_CYCLES - 1);

	// ****************************************************************
	// comparator conditioning
	// ****************************************************************
	logic digitalRailSync;   // synchronised digital comparator
	logic analogRailSync;    // synchronised analog comparator
	logic digitalRailOk;     // deglitched digital comparator
	logic analogRailOk;      // deglitched analog comparator

	// comparators are asynchronous analog outputs
	smc_glitch_filter u_dig_filter (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.rawOk   (digitalRailCmp),
		.syncOk  (digitalRailSync),
		.filtOk  (digitalRailOk)
	);

	smc_glitch_filter u_ana_filter (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.rawOk   (analogRailCmp),
		.syncOk  (analogRailSync),
		.filtOk  (analogRailOk)
	);

	// ****************************************************************
	// decode
	// ****************************************************************
	logic      ctrlHit;      // request addresses the control byte
	logic      ctrlWrite;    // byte write to the control byte
	logic      ctrlRead;     // byte read of the control byte
	logic      bothRailsOk;  // both supplies above trip level
	logic      railLow;      // a supply below trip while monitoring
	smc_ctrl_t wrFields;     // write data viewed as control fields

	// whole byte only: no bit-level access to this register
	assign ctrlHit   = (sfrReq.addr == SMC_CTRL_ADDR);
	assign ctrlWrite = ctrlHit && sfrReq.wrEn;
	assign ctrlRead  = ctrlHit && sfrReq.rdEn;
	assign wrFields  = smc_ctrl_t'(sfrReq.wrData[5:0]);

	assign bothRailsOk = digitalRailOk && analogRailOk;

	// ****************************************************************
	// control register state
	// ****************************************************************
	smc_ctrl_t                ctrl_ff;     // software-held fields
	smc_ctrl_t                nxt_ctrl;
	smc_settle_state_t        state_ff;    // settling state
	smc_settle_state_t        nxt_state;
	logic [SMC_SETTLE_W-1:0]  settle_ff;   // settling cycle count
	logic [SMC_SETTLE_W-1:0]  nxt_settle;
	logic                     settleDone;  // last settling cycle

	assign settleDone = (state_ff == SMC_SETTLE)
		&& (settle_ff == SETTLE_LAST) && bothRailsOk;

	// comparators are unpowered when monitoring is off, so ignore them
	assign railLow = ctrl_ff.monitorEnable && !bothRailsOk;

	// fields, flag and settling timer in one next-state process
	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_state  = state_ff;
		nxt_settle = settle_ff;

		// software write to the writable fields
		if (ctrlWrite) begin
			nxt_ctrl.monitorEnable  = wrFields.monitorEnable;
			nxt_ctrl.digitalTripSel = wrFields.digitalTripSel;
			nxt_ctrl.analogTripSel  = wrFields.analogTripSel;
			// a zero only sticks while both rails are good
			if (wrFields.lowSupplyFlag || bothRailsOk) begin
				nxt_ctrl.lowSupplyFlag = wrFields.lowSupplyFlag;
			end
		end

		// settling timer
		case (state_ff)
			SMC_IDLE: begin
				nxt_settle = SMC_SETTLE_ZERO;
				// flag up and supplies back: start counting
				if (ctrl_ff.lowSupplyFlag && bothRailsOk) begin
					nxt_state = SMC_SETTLE;
				end
			end
			SMC_SETTLE: begin
				if (!bothRailsOk || !ctrl_ff.lowSupplyFlag) begin
					// drop-out abandons the run, restart from zero
					nxt_state  = SMC_IDLE;
					nxt_settle = SMC_SETTLE_ZERO;
				end else if (settleDone) begin
					// supply stayed good the whole interval; a software
					// set in the same cycle still wins over this clear
					nxt_ctrl.lowSupplyFlag = ctrlWrite
						&& wrFields.lowSupplyFlag;
					nxt_state  = SMC_IDLE;
					nxt_settle = SMC_SETTLE_ZERO;
				end else begin
					nxt_settle = settle_ff + 23'h000001;
				end
			end
			default: begin
				nxt_state  = SMC_IDLE;
				nxt_settle = SMC_SETTLE_ZERO;
			end
		endcase

		// hardware set last, so it wins over any clear
		if (railLow) begin
			nxt_ctrl.lowSupplyFlag = 1'b1;
		end
	end

	// reset loads the documented byte image
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff   <= SMC_CTRL_INIT;
			state_ff  <= SMC_IDLE;
			settle_ff <= SMC_SETTLE_ZERO;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			state_ff  <= nxt_state;
			settle_ff <= nxt_settle;
		end
	end

	// ****************************************************************
	// read data and interrupt request
	// ****************************************************************
	logic [7:0] rdData_ff;   // registered read data
	logic [7:0] nxt_rdData;
	logic       irq_ff;      // registered interrupt request
	logic       nxt_irq;

	// status bits show the comparators live, not the filtered view
	always_comb begin
		nxt_rdData = 8'h00;
		if (ctrlRead) begin
			nxt_rdData[SMC_BIT_DIG_OK] = digitalRailSync;
			nxt_rdData[SMC_BIT_ANA_OK] = analogRailSync;
			nxt_rdData[5:0]            = ctrl_ff;
		end
		nxt_irq = ctrl_ff.lowSupplyFlag && monitorIrqEnable;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdData_ff <= 8'h00;
			irq_ff    <= 1'b0;
		end else begin
			rdData_ff <= nxt_rdData;
			irq_ff    <= nxt_irq;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign sfrRdData      = rdData_ff;
	assign lowSupplyIrq   = irq_ff;
	assign monitorEnable  = ctrl_ff.monitorEnable;
	assign digitalTripSel = ctrl_ff.digitalTripSel;
	assign analogTripSel  = ctrl_ff.analogTripSel;

	// ****************************************************************
	// checks
	// ****************************************************************
	enable_write_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		ctrlWrite |=> (monitorEnable == $past(sfrReq.wrData[0])))
		else $error("enable bit did not follow write");

	digital_status_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		ctrlRead |=> (sfrRdData[7] == $past(digitalRailSync)))
		else $error("bit 7 does not show digital comparator");

	analog_status_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		ctrlRead |=> (sfrRdData[6] == $past(analogRailSync)))
		else $error("bit 6 does not show analog comparator");

	flag_set_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		railLow |=> ctrl_ff.lowSupplyFlag)
		else $error("low supply did not set the flag");

	settle_start_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == SMC_IDLE && ctrl_ff.lowSupplyFlag && bothRailsOk)
			|=> (state_ff == SMC_SETTLE) && (settle_ff == SMC_SETTLE_ZERO))
		else $error("settling count did not start");

	settle_clear_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(settleDone && !railLow && !ctrlWrite)
			|=> !ctrl_ff.lowSupplyFlag && (state_ff == SMC_IDLE))
		else $error("flag not cleared at end of settling");

	sw_clear_block_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(ctrlWrite && !sfrReq.wrData[5] && !bothRailsOk
			&& ctrl_ff.lowSupplyFlag) |=> ctrl_ff.lowSupplyFlag)
		else $error("software cleared flag while a rail is low");

	trip_select_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		ctrlWrite |=> (digitalTripSel == $past(sfrReq.wrData[4:3]))
			&& (analogTripSel == $past(sfrReq.wrData[2:1])))
		else $error("trip select did not follow write");

	irq_gate_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		!monitorIrqEnable ##1 !monitorIrqEnable |-> !lowSupplyIrq)
		else $error("interrupt raised while disabled");

	settle_restart_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == SMC_SETTLE && !bothRailsOk)
			|=> (settle_ff == SMC_SETTLE_ZERO) && (state_ff == SMC_IDLE))
		else $error("settling count not abandoned on drop-out");

	// flag only falls through the settle timer or a software write
	flag_fall_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		$fell(ctrl_ff.lowSupplyFlag)
			|-> $past(settleDone) || $past(ctrlWrite))
		else $error("flag fell without settle or write");

	// flag only rises on a low rail or a software one
	flag_rise_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(ctrl_ff.lowSupplyFlag) |-> $past(railLow)
			|| ($past(ctrlWrite) && $past(sfrReq.wrData[5])))
		else $error("flag rose without a cause");

	// monitor off and no write: nothing may raise the flag
	disabled_quiet_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(!ctrl_ff.monitorEnable && !ctrlWrite && !ctrl_ff.lowSupplyFlag)
			|=> !ctrl_ff.lowSupplyFlag)
		else $error("flag set while monitoring off");

	// request follows flag and enable one cycle later
	irq_follow_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(ctrl_ff.lowSupplyFlag && monitorIrqEnable) |=> lowSupplyIrq)
		else $error("interrupt missing for enabled flag");

	irq_source_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		lowSupplyIrq |-> $past(ctrl_ff.lowSupplyFlag)
			&& $past(monitorIrqEnable))
		else $error("interrupt without flag and enable");

	// counter steps by one while the run is unbroken
	settle_count_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == SMC_SETTLE && bothRailsOk && ctrl_ff.lowSupplyFlag
			&& !settleDone)
			|=> (settle_ff == $past(settle_ff) + 23'h000001))
		else $error("settling count did not advance");

	// the count never runs past its last value
	settle_bound_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == SMC_SETTLE) |-> (settle_ff <= SETTLE_LAST))
		else $error("settling count ran past its end");

	// idle always holds a cleared count, so a restart begins at zero
	idle_zero_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(state_ff == SMC_IDLE) |-> (settle_ff == SMC_SETTLE_ZERO))
		else $error("count left standing while idle");

	// read data is zero except right after a read hit
	read_idle_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		!ctrlRead |=> (sfrRdData == 8'h00))
		else $error("read data not idle after no read");

	read_image_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		ctrlRead |=> (sfrRdData[5:0] == $past(ctrl_ff)))
		else $error("read image does not match control fields");

endmodule // smc_supply_monitor

//--- inc/smc_pkg.sv
// constants and types shared by the supply monitor control logic
// Behaviour
// - bit 0 written one enables monitoring
// - bit 7 reads digital comparator state directly
// - bit 6 reads analog comparator state directly
// - hardware sets low flag on low comparator
// - both comparators good start 250 ms count
// - count expiry clears the low flag
// - software zero cannot clear flag while low
// - bits 4:3 select digital rail trip level
// - bits 2:1 select analog rail trip level
// - flag interrupts only when enable bit set
// - comparator glitches are filtered out first
package smc_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] SMC_CTRL_ADDR  = 8'hdf; // control byte address
	localparam logic [7:0] SMC_CTRL_RESET = 8'hde; // value after reset

	// bit positions inside the control byte
	localparam int SMC_BIT_DIG_OK   = 7; // digital comparator, read only
	localparam int SMC_BIT_ANA_OK   = 6; // analog comparator, read only
	localparam int SMC_BIT_FLAG     = 5; // low supply flag
	localparam int SMC_BIT_DTRIP_HI = 4; // digital trip select, high bit
	localparam int SMC_BIT_DTRIP_LO = 3; // digital trip select, low bit
	localparam int SMC_BIT_ATRIP_HI = 2; // analog trip select, high bit
	localparam int SMC_BIT_ATRIP_LO = 1; // analog trip select, low bit
	localparam int SMC_BIT_ENABLE   = 0; // monitor enable

	// trip level codes, same table for both rails
	localparam logic [1:0] SMC_TRIP_4V63 = 2'h0; // 4.63 V
	localparam logic [1:0] SMC_TRIP_3V08 = 2'h1; // 3.08 V
	localparam logic [1:0] SMC_TRIP_2V93 = 2'h2; // 2.93 V
	localparam logic [1:0] SMC_TRIP_2V63 = 2'h3; // 2.63 V

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int SMC_CLK_HZ    = 20000000; // core clock rate
	localparam int SMC_SETTLE_MS = 250;      // supply good settling time
	// least time, divides exactly at this rate
	localparam int SMC_SETTLE_CYCLES = (SMC_CLK_HZ / 1000) * SMC_SETTLE_MS;
	localparam int SMC_SETTLE_W      = 23;   // holds 5,000,000
	localparam logic [SMC_SETTLE_W-1:0] SMC_SETTLE_ZERO = 23'h000000;

	// glitch filter: level must hold this many cycles to be believed
	localparam logic [3:0] SMC_FILTER_LAST = 4'hf; // 16 cycles
	localparam logic [3:0] SMC_FILTER_ZERO = 4'h0;

	// ****************************************************************
	// types
	// ****************************************************************
	// software-held part of the control byte, bits 5..0
	typedef struct packed {
		logic       lowSupplyFlag;   // bit 5
		logic [1:0] digitalTripSel;  // bits 4:3
		logic [1:0] analogTripSel;   // bits 2:1
		logic       monitorEnable;   // bit 0
	} smc_ctrl_t;

	localparam smc_ctrl_t SMC_CTRL_INIT = smc_ctrl_t'(SMC_CTRL_RESET[5:0]);

	// byte-wide register port strobes with data
	typedef struct packed {
		logic [7:0] addr;    // register address
		logic       wrEn;    // write strobe
		logic       rdEn;    // read strobe
		logic [7:0] wrData;  // write data
	} smc_sfr_req_t;

	typedef enum logic {
		SMC_IDLE,            // waiting for both rails good
		SMC_SETTLE           // counting the settling time
	} smc_settle_state_t;

endpackage

//--- logic/smc_glitch_filter.sv
// synchroniser and glitch filter for one comparator output
`timescale 1ns/100ps
module smc_glitch_filter
	import smc_pkg::*;
(
	input  wire logic clk_sys,  // core clock
	input  wire logic rst_b,    // async reset, active low
	input  wire logic rawOk,    // comparator, asynchronous
	output logic      syncOk,   // synchronised level
	output logic      filtOk    // deglitched level
);

	// ****************************************************************
	// two-stage synchroniser
	// ****************************************************************
	logic       sync1_ff;      // first stage, read only by sync2
	logic       sync2_ff;      // second stage
	logic       filt_ff;       // accepted level
	logic [3:0] cnt_ff;        // stable run length
	logic       nxt_filt;
	logic [3:0] nxt_cnt;

	// rails assumed good at reset, matching reset byte
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			filt_ff  <= 1'b1;
			cnt_ff   <= SMC_FILTER_ZERO;
		end else begin
			sync1_ff <= rawOk;
			sync2_ff <= sync1_ff;
			filt_ff  <= nxt_filt;
			cnt_ff   <= nxt_cnt;
		end
	end

	// ****************************************************************
	// filter
	// ****************************************************************
	// any return to the old level restarts the run, so a short
	// spike never reaches the flag; costs 16 cycles of latency
	always_comb begin
		nxt_filt = filt_ff;
		nxt_cnt  = SMC_FILTER_ZERO;
		if (sync2_ff != filt_ff) begin
			if (cnt_ff == SMC_FILTER_LAST) begin
				nxt_filt = sync2_ff;
			end else begin
				nxt_cnt = cnt_ff + 4'h1;
			end
		end
	end

	assign syncOk = sync2_ff;
	assign filtOk = filt_ff;

	// filtered level only moves after a full stable run
	filt_change_a: assert property (
		@(posedge clk_sys) disable iff (!rst_b)
		(filt_ff != nxt_filt) |-> (cnt_ff == SMC_FILTER_LAST)
			&& (sync2_ff == nxt_filt))
		else $error("filtered level moved without stable run");

endmodule // smc_glitch_filter

//--- sim/smc_cmp_model.sv
// behavioural comparator standing in for one supply rail
`timescale 1ns/100ps
module smc_cmp_model
	import smc_pkg::*;
(
	input  wire logic [1:0] tripSel, // selected trip code
	input  var int          railMv,  // rail level in millivolts
	output logic            railOk   // high while rail above trip
);
	int tripMv; // threshold for the chosen code

	// ****************************************************************
	// trip table, same for both rails
	// ****************************************************************
	// no hysteresis: a real comparator is no kinder at the edge
	always_comb begin
		case (tripSel)
			SMC_TRIP_4V63: tripMv = 4630;
			SMC_TRIP_3V08: tripMv = 3080;
			SMC_TRIP_2V93: tripMv = 2930;
			default:       tripMv = 2630;
		endcase
		railOk = (railMv > tripMv);
	end
endmodule // smc_cmp_model

//--- sim/tb.sv
// self-checking bench for the supply monitor control logic
`timescale 1ns/100ps
module tb;
	import smc_pkg::*;
	// shortened count, long enough to tell a restart from a resume
	localparam int SETTLE = 60;
	typedef struct packed {
		logic [7:0] wData;  // byte written
		logic [7:0] rdExp;  // image read back
		logic [1:0] dSel;   // digital trip code
		logic [1:0] aSel;   // analog trip code
	} smc_row_t;
	smc_row_t     rows [6] = '{
		'{8'h01, 8'hc1, 2'h0, 2'h0}, '{8'h0b, 8'hcb, 2'h1, 2'h1},
		'{8'h15, 8'hd5, 2'h2, 2'h2}, '{8'h1f, 8'hdf, 2'h3, 2'h3},
		'{8'h13, 8'hd3, 2'h2, 2'h1}, '{8'hc8, 8'hc8, 2'h1, 2'h0}};
	logic         clk_sys = 1'b0;           // core clock
	logic         rst_b = 1'b0;             // reset, active low
	smc_sfr_req_t sfrReq = '0;              // register port
	logic [7:0]   sfrRdData;                // read data
	logic         digitalRailCmp;           // model outputs
	logic         analogRailCmp;
	logic         monitorIrqEnable = 1'b0;  // enable register bit
	logic         monitorEnable;
	logic         lowSupplyIrq;
	logic [1:0]   digitalTripSel;
	logic [1:0]   analogTripSel;
	int           digMv = 5000;             // rail levels
	int           anaMv = 5000;
	int           n_fail = 0;
	int           n_tests = 0;
	int           cycles = 0;

	always #25 clk_sys = ~clk_sys; // 20 MHz

	smc_supply_monitor #(.SETTLE_CYCLES(SETTLE)) dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .sfrReq(sfrReq),
		.sfrRdData(sfrRdData), .digitalRailCmp(digitalRailCmp),
		.analogRailCmp(analogRailCmp),
		.monitorIrqEnable(monitorIrqEnable),
		.monitorEnable(monitorEnable), .digitalTripSel(digitalTripSel),
		.analogTripSel(analogTripSel), .lowSupplyIrq(lowSupplyIrq));
	smc_cmp_model digCmp (.tripSel(digitalTripSel), .railMv(digMv),
		.railOk(digitalRailCmp));
	smc_cmp_model anaCmp (.tripSel(analogTripSel), .railMv(anaMv),
		.railOk(analogRailCmp));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	// inputs always move 5 ns after the edge, never on it
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#5;
	endtask

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfrReq.addr = a;
		sfrReq.wrData = d;
		sfrReq.wrEn = 1'b1;
		tick(1);
		sfrReq.wrEn = 1'b0;
	endtask

	// read data stands only the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input string nm);
		sfrReq.addr = a;
		sfrReq.rdEn = 1'b1;
		tick(1);
		sfrReq.rdEn = 1'b0;
		chk(nm, e, sfrRdData);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard, far above the few hundred cycles needed
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			test_done();
		end
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		tick(12);
		chk("irq in reset", 8'h00, {7'h0, lowSupplyIrq});
		rst_b = 1'b1;
		rd(SMC_CTRL_ADDR, 8'hde, "reset image");
		chk("reset trips", 8'h0f, {4'h0, digitalTripSel, analogTripSel});
		$display("reset test done");
		// table of control writes, rails well above every trip
		foreach (rows[i]) begin
			wr(SMC_CTRL_ADDR, rows[i].wData);
			chk("enable", {7'h0, rows[i].wData[0]}, {7'h0, monitorEnable});
			chk("trips", {4'h0, rows[i].dSel, rows[i].aSel},
				{4'h0, digitalTripSel, analogTripSel});
			rd(SMC_CTRL_ADDR, rows[i].rdExp, "image");
		end
		$display("table test done");
		wr(8'h10, 8'h20);
		rd(8'h10, 8'h00, "unmapped read");
		// let the strobe stay low over one edge between reads
		tick(1);
		rd(SMC_CTRL_ADDR, 8'hc8, "after unmapped");
		$display("unmapped test done");
		// monitor off: a failing rail shows but raises nothing
		anaMv = 4000;
		tick(30);
		rd(SMC_CTRL_ADDR, 8'h88, "disabled");
		monitorIrqEnable = 1'b1;
		wr(SMC_CTRL_ADDR, 8'h01);
		tick(25);
		rd(SMC_CTRL_ADDR, 8'ha1, "flag set");
		chk("irq set", 8'h01, {7'h0, lowSupplyIrq});
		wr(SMC_CTRL_ADDR, 8'h01);
		rd(SMC_CTRL_ADDR, 8'ha1, "clear refused");
		monitorIrqEnable = 1'b0;
		tick(2);
		chk("irq masked", 8'h00, {7'h0, lowSupplyIrq});
		monitorIrqEnable = 1'b1;
		$display("low supply test done");
		// drop mid-settle: count must start again from zero
		anaMv = 5000;
		tick(31);
		anaMv = 4000;
		tick(50);
		anaMv = 5000;
		tick(60);
		rd(SMC_CTRL_ADDR, 8'he1, "settle restart");
		tick(30);
		rd(SMC_CTRL_ADDR, 8'hc1, "settle clear");
		chk("irq clear", 8'h00, {7'h0, lowSupplyIrq});
		$display("settle test done");
		// short dip must be filtered away
		digMv = 3000;
		tick(2);
		rd(SMC_CTRL_ADDR, 8'h41, "digital low");
		tick(2);
		digMv = 5000;
		tick(25);
		rd(SMC_CTRL_ADDR, 8'hc1, "glitch");
		chk("irq glitch", 8'h00, {7'h0, lowSupplyIrq});
		wr(SMC_CTRL_ADDR, 8'h21);
		rd(SMC_CTRL_ADDR, 8'he1, "soft set");
		wr(SMC_CTRL_ADDR, 8'h01);
		rd(SMC_CTRL_ADDR, 8'hc1, "soft clear");
		$display("glitch test done");
		// second reset in mid-run
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		rd(SMC_CTRL_ADDR, 8'hde, "second reset");
		$display("second reset test done");
		test_done();
	end
endmodule // tb
